// ==== logic/dcp_defines.svh ====
`ifndef DCP_DEFINES_SVH
`define DCP_DEFINES_SVH

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define DCP_ADDR_W          6

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DCP_OFF_CMD         6'h00
`define DCP_OFF_CFG         6'h04
`define DCP_OFF_PERP        6'h08
`define DCP_OFF_SWRST       6'h0c
`define DCP_OFF_EXEC        6'h10
`define DCP_OFF_STATUS      6'h14
`define DCP_OFF_DATA        6'h18
`define DCP_OFF_INT_STAT    6'h1c
`define DCP_OFF_INT_MASK    6'h20

// ----------------------------------------------------------------
// command parameter register fields
// ----------------------------------------------------------------
`define DCP_CMD_HL_LSB      0
`define DCP_CMD_HL_W        8
`define DCP_CMD_HU_LSB      8
`define DCP_CMD_HU_W        8
`define DCP_CMD_MFM_BIT     16
`define DCP_CMD_MT_BIT      17
`define DCP_CMD_ND_BIT      18
`define DCP_CMD_SIZE_LSB    20
`define DCP_CMD_SIZE_W      3
`define DCP_CMD_EOT_LSB     24
`define DCP_CMD_RESET       32'h0901_0808

// ----------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------
`define DCP_CFG_FIFO_N_BIT  0
`define DCP_CFG_THR_LSB     4
`define DCP_CFG_THR_W       4
`define DCP_CFG_PRE_LSB     8
`define DCP_CFG_LOCK_BIT    16
`define DCP_CFG_RESET       32'h0000_0001
`define DCP_CFG_MASK        32'h0001_fff1

// ----------------------------------------------------------------
// perpendicular, soft reset and execution fields
// ----------------------------------------------------------------
`define DCP_PERP_OW_BIT     7
`define DCP_SWRST_DSR_BIT   0
`define DCP_SWRST_DOR_BIT   1
`define DCP_EXEC_GO_BIT     0
`define DCP_EXEC_HEAD_BIT   1
`define DCP_EXEC_SEC_LSB    8
`define DCP_SECTOR_BASE     15'h0080

// ----------------------------------------------------------------
// interrupt events
// ----------------------------------------------------------------
`define DCP_IRQ_N           3
`define DCP_IRQ_BYTE        0
`define DCP_IRQ_EXEC_END    1
`define DCP_IRQ_HEAD_RDY    2

// ----------------------------------------------------------------
// bus responses and timing
// ----------------------------------------------------------------
`define DCP_RESP_OKAY       2'b00
`define DCP_RESP_SLVERR     2'b10
`define DCP_CLK_PERIOD_NS   8
`define DCP_TICK_PERIOD_NS  1000000
`define DCP_TICK_CYCLES     (`DCP_TICK_PERIOD_NS / `DCP_CLK_PERIOD_NS)

`endif

// ==== logic/dcp_interval_counter.sv ====
`timescale 1ns/1ps
`default_nettype none

module dcp_interval_counter #(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    input  wire logic             cancel,
    input  wire logic             tick,
    // status
    output logic                  expired
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             running;
    } dcp_cnt_state_t;

    dcp_cnt_state_t s_q;
    dcp_cnt_state_t s_d;

    // one-cycle pulse once the loaded count has run down
    assign expired = s_q.running && (s_q.count == '0) && !load && !cancel;

    // down-count on each tick; a fresh load restarts the interval
    always_comb begin
        s_d = s_q;
        if (cancel) begin
            s_d.running = 1'b0;
        end else if (load) begin
            s_d.count   = load_val;
            s_d.running = 1'b1;
        end else if (s_q.running) begin
            if (s_q.count == '0) begin
                s_d.running = 1'b0;
            end else if (tick) begin
                s_d.count = s_q.count - 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

// ==== logic/dcp_irq_status.sv ====
`timescale 1ns/1ps
`default_nettype none

module dcp_irq_status #(
    parameter int unsigned N = 3
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // events and software access
    input  wire logic [N-1:0] event_set,
    input  wire logic         rd_clear,
    input  wire logic         mask_wr,
    input  wire logic [N-1:0] mask_wdata,
    // state
    output logic [N-1:0]      status,
    output logic [N-1:0]      mask,
    output logic              irq
);

    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] mask;
    } dcp_irq_state_t;

    dcp_irq_state_t s_q;
    dcp_irq_state_t s_d;

    assign status = s_q.status;
    assign mask   = s_q.mask;
    assign irq    = |(s_q.status & s_q.mask);

    // an event in the clearing cycle survives the read
    always_comb begin
        s_d = s_q;
        if (rd_clear) begin
            s_d.status = '0;
        end
        s_d.status = s_d.status | event_set;
        if (mask_wr) begin
            s_d.mask = mask_wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

// ==== logic/dcp_param_decode.sv ====
// Operation
// - wait head-load interval before medium access
// - unload head after head-unload interval
// - lock keeps fifo, threshold, precomp over reset
// - density bit one MFM, zero FM
// - multi-track continues head 0 into head 1
// - size code gives 128 shifted bytes
// - non-DMA interrupts per byte, else DRQ/DACK
// - perpendicular bits change only with overwrite
// - fifo enable active low, disabled default
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`include "dcp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dcp_param_decode #(
    parameter int unsigned TICK_CYCLES = `DCP_TICK_CYCLES
) (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite write address
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [`DCP_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]             awprot,
    // axi4-lite write data
    input  wire logic                   wvalid,
    output logic                        wready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    // axi4-lite write response
    output logic                        bvalid,
    input  wire logic                   bready,
    output logic [1:0]                  bresp,
    // axi4-lite read address
    input  wire logic                   arvalid,
    output logic                        arready,
    input  wire logic [`DCP_ADDR_W-1:0] araddr,
    input  wire logic [2:0]             arprot,
    // axi4-lite read data
    output logic                        rvalid,
    input  wire logic                   rready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    // interrupt
    output logic                        irq,
    // head and medium sequencing
    output logic                        head_load,
    output logic                        medium_go,
    input  wire logic                   exec_end,
    input  wire logic                   sector_done,
    output logic                        head_sel,
    output logic [7:0]                  sector_num,
    // recording parameters
    output logic                        mfm_mode,
    output logic [14:0]                 sector_bytes,
    output logic [3:0]                  perpendicular_drive_bits,
    output logic                        fifo_enable_n,
    output logic [3:0]                  fifo_threshold,
    output logic [7:0]                  precomp_start_track,
    // data byte path
    input  wire logic                   byte_valid,
    input  wire logic [7:0]             byte_data,
    output logic                        dma_req,
    input  wire logic                   dma_ack,
    output logic [7:0]                  dma_data
);

    dcp_pkg::dcp_state_t s_q;
    dcp_pkg::dcp_state_t s_d;

    logic                  soft_rst;
    logic                  wr_fire;
    logic                  rd_fire;
    logic                  hl_load;
    logic                  hu_load;
    logic                  hu_cancel;
    logic                  hl_expired;
    logic                  hu_expired;
    logic                  int_rd;
    logic                  mask_wr;
    logic [31:0]           wmask;
    logic [31:0]           wmerged;
    logic [`DCP_IRQ_N-1:0] irq_events;
    logic [`DCP_IRQ_N-1:0] irq_stat;
    logic [`DCP_IRQ_N-1:0] irq_mask;

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign awready    = !s_q.aw_held;
    assign wready     = !s_q.w_held;
    assign bvalid     = s_q.bvalid;
    assign bresp      = s_q.bresp;
    assign arready    = !s_q.rvalid;
    assign rvalid     = s_q.rvalid;
    assign rdata      = s_q.rdata;
    assign rresp      = s_q.rresp;
    assign head_load  = (s_q.head_st != dcp_pkg::HD_IDLE);
    assign medium_go  = (s_q.head_st == dcp_pkg::HD_EXEC);
    assign head_sel   = s_q.head;
    assign sector_num = s_q.sector;
    assign mfm_mode   = s_q.cmd[`DCP_CMD_MFM_BIT];
    assign sector_bytes = `DCP_SECTOR_BASE
                        << s_q.cmd[`DCP_CMD_SIZE_LSB +: `DCP_CMD_SIZE_W];
    assign perpendicular_drive_bits = s_q.perp;
    assign fifo_enable_n       = s_q.cfg[`DCP_CFG_FIFO_N_BIT];
    assign fifo_threshold      = s_q.cfg[`DCP_CFG_THR_LSB +: `DCP_CFG_THR_W];
    assign precomp_start_track = s_q.cfg[`DCP_CFG_PRE_LSB +: 8];
    // dma request only in dma mode; handshake clears it
    assign dma_req    = s_q.pending && !s_q.cmd[`DCP_CMD_ND_BIT];
    assign dma_data   = s_q.data;

    // ----------------------------------------------------------------
    // bus handshakes and byte-lane merge
    // ----------------------------------------------------------------
    assign wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    assign rd_fire = arvalid && !s_q.rvalid;
    assign wmask   = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}},
                      {8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
    assign wmerged = s_q.w_data & wmask;
    assign soft_rst = wr_fire && (s_q.aw_addr == `DCP_OFF_SWRST)
                    && (wmerged[`DCP_SWRST_DSR_BIT] || wmerged[`DCP_SWRST_DOR_BIT]);
    assign int_rd  = rd_fire && (araddr == `DCP_OFF_INT_STAT);
    assign mask_wr = wr_fire && (s_q.aw_addr == `DCP_OFF_INT_MASK) && s_q.w_strb[0];

    // events: per-byte interrupt only in non-dma mode
    assign irq_events[`DCP_IRQ_BYTE]     = byte_valid && s_q.cmd[`DCP_CMD_ND_BIT];
    assign irq_events[`DCP_IRQ_EXEC_END] = exec_end && (s_q.head_st == dcp_pkg::HD_EXEC);
    assign irq_events[`DCP_IRQ_HEAD_RDY] = hl_expired;

    // ----------------------------------------------------------------
    // head interval counters and interrupt status
    // ----------------------------------------------------------------
    dcp_interval_counter #(
        .WIDTH    (`DCP_CMD_HL_W)
    ) u_head_load_cnt (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (hl_load),
        .load_val (s_q.cmd[`DCP_CMD_HL_LSB +: `DCP_CMD_HL_W]),
        .cancel   (soft_rst),
        .tick     (s_q.tick),
        .expired  (hl_expired)
    );

    dcp_interval_counter #(
        .WIDTH    (`DCP_CMD_HU_W)
    ) u_head_unload_cnt (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (hu_load),
        .load_val (s_q.cmd[`DCP_CMD_HU_LSB +: `DCP_CMD_HU_W]),
        .cancel   (hu_cancel),
        .tick     (s_q.tick),
        .expired  (hu_expired)
    );

    dcp_irq_status #(
        .N          (`DCP_IRQ_N)
    ) u_irq (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .event_set  (irq_events),
        .rd_clear   (int_rd),
        .mask_wr    (mask_wr),
        .mask_wdata (wmerged[`DCP_IRQ_N-1:0]),
        .status     (irq_stat),
        .mask       (irq_mask),
        .irq        (irq)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        hl_load   = 1'b0;
        hu_load   = 1'b0;
        hu_cancel = soft_rst;
        s_d.tick  = 1'b0;

        // interval time base: one pulse per tick period
        if (s_q.tick_cnt >= TICK_CYCLES - 1) begin
            s_d.tick_cnt = '0;
            s_d.tick     = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
        end

        // address and data are captured independently
        if (awvalid && !s_q.aw_held) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && !s_q.w_held) begin
            s_d.w_held = 1'b1;
            s_d.w_data = wdata;
            s_d.w_strb = wstrb;
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end

        // register writes
        if (wr_fire) begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = `DCP_RESP_OKAY;
            case (s_q.aw_addr)
                `DCP_OFF_CMD: begin
                    s_d.cmd = (s_q.cmd & ~wmask) | wmerged;
                end
                `DCP_OFF_CFG: begin
                    s_d.cfg = ((s_q.cfg & ~wmask) | wmerged) & `DCP_CFG_MASK;
                end
                `DCP_OFF_PERP: begin
                    if (wmerged[`DCP_PERP_OW_BIT]) begin
                        s_d.perp = wmerged[3:0];
                    end
                end
                `DCP_OFF_SWRST, `DCP_OFF_INT_MASK: begin
                end
                `DCP_OFF_EXEC: begin
                    // a start while unloading reuses the still-loaded head
                    if (wmerged[`DCP_EXEC_GO_BIT]) begin
                        if (s_q.head_st == dcp_pkg::HD_IDLE) begin
                            s_d.head_st = dcp_pkg::HD_LOAD;
                            hl_load     = 1'b1;
                        end else if (s_q.head_st == dcp_pkg::HD_UNLOAD) begin
                            s_d.head_st = dcp_pkg::HD_EXEC;
                            hu_cancel   = 1'b1;
                        end
                        if (s_q.head_st == dcp_pkg::HD_IDLE ||
                            s_q.head_st == dcp_pkg::HD_UNLOAD) begin
                            s_d.head   = wmerged[`DCP_EXEC_HEAD_BIT];
                            s_d.sector = wmerged[`DCP_EXEC_SEC_LSB +: 8];
                        end
                    end
                end
                default: begin
                    s_d.bresp = `DCP_RESP_SLVERR;
                end
            endcase
        end

        // register reads
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = `DCP_RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            case (araddr)
                `DCP_OFF_CMD:      s_d.rdata = s_q.cmd;
                `DCP_OFF_CFG:      s_d.rdata = s_q.cfg;
                `DCP_OFF_PERP:     s_d.rdata[3:0] = s_q.perp;
                `DCP_OFF_SWRST, `DCP_OFF_EXEC: begin
                end
                `DCP_OFF_STATUS: begin
                    s_d.rdata = {1'b0, sector_bytes, s_q.sector,
                                 1'b0, s_q.pending, s_q.head, 1'b0, s_q.head_st};
                end
                `DCP_OFF_DATA: begin
                    s_d.rdata[7:0] = s_q.data;
                    if (s_q.cmd[`DCP_CMD_ND_BIT]) begin
                        s_d.pending = 1'b0;
                    end
                end
                `DCP_OFF_INT_STAT: s_d.rdata[`DCP_IRQ_N-1:0] = irq_stat;
                `DCP_OFF_INT_MASK: s_d.rdata[`DCP_IRQ_N-1:0] = irq_mask;
                default: begin
                    s_d.rresp = `DCP_RESP_SLVERR;
                end
            endcase
        end

        // byte path: a new byte overwrites an unserved one
        if (dma_req && dma_ack) begin
            s_d.pending = 1'b0;
        end
        if (byte_valid) begin
            s_d.data    = byte_data;
            s_d.pending = 1'b1;
        end

        // head sequencing
        case (s_q.head_st)
            dcp_pkg::HD_IDLE: begin
            end
            dcp_pkg::HD_LOAD: begin
                if (hl_expired) begin
                    s_d.head_st = dcp_pkg::HD_EXEC;
                end
            end
            dcp_pkg::HD_EXEC: begin
                if (exec_end) begin
                    s_d.head_st = dcp_pkg::HD_UNLOAD;
                    hu_load     = 1'b1;
                end else if (sector_done) begin
                    if (s_q.sector != s_q.cmd[`DCP_CMD_EOT_LSB +: 8]) begin
                        s_d.sector = s_q.sector + 8'h01;
                    end else if (s_q.cmd[`DCP_CMD_MT_BIT] && !s_q.head) begin
                        s_d.head   = 1'b1;
                        s_d.sector = 8'h01;
                    end
                end
            end
            dcp_pkg::HD_UNLOAD: begin
                if (hu_expired && s_d.head_st == dcp_pkg::HD_UNLOAD) begin
                    s_d.head_st = dcp_pkg::HD_IDLE;
                end
            end
            default: begin
                s_d.head_st = dcp_pkg::HD_IDLE;
            end
        endcase

        // software reset: lock decides whether config returns to default
        if (soft_rst) begin
            s_d.head_st = dcp_pkg::HD_IDLE;
            s_d.pending = 1'b0;
            if (!s_q.cfg[`DCP_CFG_LOCK_BIT]) begin
                s_d.cfg = `DCP_CFG_RESET;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q         <= '0;
            s_q.cmd     <= `DCP_CMD_RESET;
            s_q.cfg     <= `DCP_CFG_RESET;
            s_q.head_st <= dcp_pkg::HD_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

// ==== logic/dcp_pkg.sv ====
`include "dcp_defines.svh"

package dcp_pkg;

    // one-hot head sequencing states
    typedef enum logic [3:0] {
        HD_IDLE   = 4'b0001,
        HD_LOAD   = 4'b0010,
        HD_EXEC   = 4'b0100,
        HD_UNLOAD = 4'b1000
    } dcp_head_state_t;

    // whole state of the main module
    typedef struct packed {
        logic                    aw_held;
        logic [`DCP_ADDR_W-1:0]  aw_addr;
        logic                    w_held;
        logic [31:0]             w_data;
        logic [3:0]              w_strb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [1:0]              rresp;
        logic [31:0]             rdata;
        logic [31:0]             cmd;
        logic [31:0]             cfg;
        logic [3:0]              perp;
        dcp_head_state_t         head_st;
        logic                    head;
        logic [7:0]              sector;
        logic [7:0]              data;
        logic                    pending;
        logic [31:0]             tick_cnt;
        logic                    tick;
    } dcp_state_t;

endpackage

// ==== verification/dcp_dma_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcp_dma_model (
    // clock, reset and pacing
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       slow,
    // request side
    input  wire logic       dma_req,
    input  wire logic [7:0] dma_data,
    output logic            dma_ack,
    output logic            got,
    output logic [7:0]      got_data
);
    logic [1:0] wait_q;
    // ack stands until the edge that takes it; slow mode lets a request stand a while
    always_ff @(posedge aclk) begin
        got <= aresetn && dma_ack;
        if (!aresetn) begin
            dma_ack <= 1'b0;
            wait_q  <= 2'h0;
        end else if (dma_ack) begin
            dma_ack  <= 1'b0;
            got_data <= dma_data;
            wait_q   <= 2'h3;
        end else if (dma_req && (!slow || wait_q == 2'h0)) begin
            dma_ack <= 1'b1;
        end else if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end
    end
endmodule
`default_nettype wire

// ==== verification/dcp_param_decode_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module dcp_param_decode_sva #(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        head_load,
    input wire logic        medium_go,
    input wire logic        head_sel,
    input wire logic [7:0]  sector_num,
    input wire logic        sector_done,
    input wire logic [14:0] sector_bytes,
    input wire logic        fifo_enable_n,
    input wire logic        byte_valid,
    input wire logic [7:0]  byte_data,
    input wire logic        dma_req,
    input wire logic        dma_ack,
    input wire logic [7:0]  dma_data
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_go_needs_head: assert property (medium_go |-> head_load)
        else $error("medium access without head");
    a_load_first: assert property ($rose(head_load) |-> !medium_go [*2])
        else $error("no head load wait");
    a_go_after_count: assert property ($rose(medium_go) |-> $past(head_load, 2))
        else $error("load counter skipped");
    a_unload_late: assert property ($fell(medium_go) && head_load |=> head_load)
        else $error("head unloaded early");
    a_unload_order: assert property ($fell(head_load) |-> !$past(medium_go))
        else $error("unload during access");
    a_size_decode: assert property ($onehot(sector_bytes) && sector_bytes[6:0] == 7'h00)
        else $error("bad sector size");
    a_fifo_default: assert property ($rose(aresetn) |-> fifo_enable_n)
        else $error("fifo not disabled");
    a_dma_hold: assert property (dma_req && !dma_ack |=> dma_req)
        else $error("request withdrawn");
    a_dma_taken: assert property (dma_req && dma_ack && !byte_valid |=> !dma_req)
        else $error("request after ack");
    a_byte_latch: assert property (byte_valid |=> dma_data == $past(byte_data))
        else $error("byte not latched");
    a_head_wrap: assert property ($rose(head_sel) && $past(medium_go)
        |-> $past(sector_done) && sector_num == 8'h01)
        else $error("bad head wrap");
endmodule
bind dcp_param_decode dcp_param_decode_sva #(.TICK_CYCLES(TICK_CYCLES)) i_dcp_param_decode_sva (
    .aclk, .aresetn, .head_load, .medium_go, .head_sel, .sector_num, .sector_done,
    .sector_bytes, .fifo_enable_n, .byte_valid, .byte_data, .dma_req, .dma_ack, .dma_data);
`default_nettype wire

// ==== verification/disk_command_param_decode_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module disk_command_param_decode_tb;
    localparam int TK = 4;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow, ha, hb, hw;
    logic awready, wready, bvalid, arready, rvalid, irq, head_load, medium_go, head_sel;
    logic mfm_mode, fifo_enable_n, dma_req, dma_ack, got;
    logic [1:0] bresp, rresp, rr;
    logic [5:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [2:0] ev;
    logic [7:0] sector_num, precomp_start_track, dma_data, got_data, b, q[$];
    logic [14:0] sector_bytes;
    logic [3:0] perpendicular_drive_bits, fifo_threshold;
    int n_errors, comparisons, n, m;
    dcp_param_decode #(.TICK_CYCLES(TK)) i_dcp_param_decode (.aclk, .aresetn, .awvalid,
        .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata,
        .rresp, .irq, .head_load, .medium_go, .exec_end(ev[1]), .sector_done(ev[0]), .head_sel,
        .sector_num, .mfm_mode, .sector_bytes, .perpendicular_drive_bits, .fifo_enable_n,
        .fifo_threshold, .precomp_start_track, .byte_valid(ev[2]), .byte_data(b), .dma_req,
        .dma_ack, .dma_data);
    dcp_dma_model i_dcp_dma_model (.aclk, .aresetn, .slow, .dma_req, .dma_data, .dma_ack,
        .got, .got_data);
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic final_report();
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // readys sampled at the negedge, released after the rising edge that took them
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge aclk) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(negedge aclk) {ha, hb, hw, rr} = {awready, bvalid, wready, bresp};
            @(posedge aclk) if (ha) awvalid <= 0;
            if (hw) wvalid <= 0;
        end while (!hb);
        bready <= 0;
        @(negedge aclk);
    endtask
    task automatic rdr(input logic [5:0] a);
        @(posedge aclk) {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(negedge aclk) {ha, hb, rd, rr} = {arready, rvalid, rdata, rresp};
            @(posedge aclk) if (ha) arvalid <= 0;
        end while (!hb);
        rready <= 0;
        @(negedge aclk);
    endtask
    task automatic pulse(input int k);
        @(posedge aclk) ev[k] <= 1;
        @(posedge aclk) ev <= 0;
        @(negedge aclk);
    endtask
    // count cycles until a level takes the wanted value
    task automatic wt(input logic w, input int sel);
        n = 0;
        while ((sel ? head_load : medium_go) !== w) begin
            @(negedge aclk) n++;
        end
    endtask
    initial begin
        aclk = 0;
        forever #4 aclk = ~aclk;
    end
    initial begin
        repeat (6000) @(posedge aclk);
        n_errors++;
        final_report();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, ev, slow, b} = 0;
        {awaddr, araddr, wdata} = 0;
        n = $urandom(66);
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        rdr(6'h00); chk("cmd", rd, 32'h0901_0808);
        chk("fifo_n", fifo_enable_n, 1);
        rdr(6'h24); chk("unmapped", rr, 2); wr(6'h24, 0); chk("wresp", rr, 2);
        for (int s = 0; s < 8; s++) begin
            m = $urandom % 2;
            wr(6'h00, {8'h02, 1'b0, 3'(s), 3'b001, m[0], 8'h02, 8'h02});
            chk("size", sector_bytes, 32'h80 << s);
            chk("mfm", mfm_mode, m);
        end
        wr(6'h08, 32'h05); chk("perp", perpendicular_drive_bits, 0);
        wr(6'h08, 32'h85); chk("perp", perpendicular_drive_bits, 5);
        wr(6'h04, 32'h3420); chk("fifo_n", fifo_enable_n, 0);
        wr(6'h0c, 1); rdr(6'h04); chk("cfg", rd, 1);
        wr(6'h04, 32'h1_3420); wr(6'h0c, 2); rdr(6'h04); chk("cfg", rd, 32'h1_3420);
        chk("pre", {precomp_start_track, fifo_threshold}, 12'h342);
        wr(6'h20, 7); wr(6'h10, 32'h0101);
        chk("go", {head_load, medium_go}, 2);
        wt(1, 0); chk("load", n >= 2 * TK - 3 && n <= 3 * TK + 3, 1);
        chk("irq", irq, 1);
        pulse(0); pulse(0); chk("wrap", {head_sel, sector_num}, 9'h101);
        pulse(1); wt(0, 1); chk("unload", n >= 2 * TK - 2 && n <= 3 * TK + 3, 1);
        rdr(6'h1c); chk("irq", irq, 0); chk("istat", rd[2:0], 3'h6);
        for (int i = 0; i < 6; i++) begin
            @(posedge aclk) {slow, b} <= 9'($urandom);
            wr(6'h00, 32'h0202_0202 | (i % 2) << 18);
            pulse(2);
            if (i % 2) begin
                wr(6'h20, 6); chk("mask", irq, 0);
                wr(6'h20, 7); chk("irq", {irq, dma_req}, 2);
                rdr(6'h18); chk("data", rd[7:0], b);
                rdr(6'h1c); chk("byte", {irq, rd[0]}, 1);
            end else begin
                q.push_back(b);
                while (got !== 1) @(negedge aclk);
                chk("dma", got_data, q.pop_front());
            end
        end
        final_report();
    end
endmodule
`default_nettype wire
